//--- core/csn_regs.svh
// Purpose: constants of the shadowing and noise stage
// Assumes: included by the package and by the stage
// Notes:   definitions only
`ifndef CSN_REGS_SVH
`define CSN_REGS_SVH
// ==========================================
// sample format and clock
`define CSN_CLK_MHZ   250
`define CSN_W         18
`define CSN_FRAC      17
`define CSN_SAT_MAX   48'sh1ffff
`define CSN_SAT_MIN   -48'sh20000
// ==========================================
// shadowing
`define CSN_UNITY     18'h10000
`define CSN_AMP_MAX   18'h3ffff
`define CSN_DB2LOG2   32'sh00002a85
`define CSN_ACC_FRAC  30
// ==========================================
// noise generator, power meters and S/N0 divider
`define CSN_SEED_A    32'h5eed1234
`define CSN_SEED_B    32'h0badf00d
`define CSN_POLY      32'h80200003
`define CSN_AVG_LOG2  10
`define CSN_AVG_LEN   1024
`define CSN_DIV_STEPS 6'h2b
`endif

//--- core/csn_pkg.sv
// Purpose: types, tables and arithmetic helpers of the stage
// Assumes: x.y fixed point, sample format 1.17 signed
// Notes:   tables hold sqrt(-ln u), sqrt2*cos and 2^-f
`include "csn_regs.svh"
package csn_pkg;
  typedef logic signed [17:0] csn_smp_type;
  typedef enum logic {CSN_DIV_IDLE, CSN_DIV_RUN} csn_div_state_type;

  // ==========================================
  // lookup tables
  localparam logic [15:0] CSN_F_TAB [16] = '{16'h1127, 16'h1fae, 16'h2968, 16'h313f,
    16'h37f8, 16'h3dfc, 16'h437d, 16'h488b, 16'h4d48, 16'h51c3, 16'h55fc, 16'h5a04,
    16'h5ddb, 16'h6191, 16'h6527, 16'h689c};
  localparam logic [15:0] CSN_G_TAB [16] = '{16'h5a67, 16'h5988, 16'h57cc, 16'h5537,
    16'h51d3, 16'h4da2, 16'h48b3, 16'h4311, 16'h3cc9, 16'h35ea, 16'h2e87, 16'h26b4,
    16'h1e7d, 16'h15ff, 16'h0d48, 16'h0471};
  localparam logic [17:0] CSN_P_TAB [16] = '{18'h10000, 18'h0f525, 18'h0eac1, 18'h0e0cc,
    18'h0d745, 18'h0ce22, 18'h0c567, 18'h0bd08, 18'h0b505, 18'h0ad56, 18'h0a5ff,
    18'h09ef3, 18'h09838, 18'h091c4, 18'h08b99, 18'h085a9};

  // ==========================================
  // arithmetic helpers
  // signed product, arithmetic shift right
  function automatic logic signed [47:0] csn_mul(input logic signed [31:0] a,
                                                 input logic signed [31:0] b,
                                                 input int sh);
    return (48'(a) * 48'(b)) >>> sh;
  endfunction

  // clamp to the sample range, sign never flips
  function automatic csn_smp_type csn_sat(input logic signed [47:0] v);
    if (v > `CSN_SAT_MAX) return csn_smp_type'(`CSN_SAT_MAX);
    if (v < `CSN_SAT_MIN) return csn_smp_type'(`CSN_SAT_MIN);
    return csn_smp_type'(v[17:0]);
  endfunction

  function automatic logic csn_ovf(input logic signed [47:0] v);
    return (v > `CSN_SAT_MAX) || (v < `CSN_SAT_MIN);
  endfunction

  // 32 galois steps, so successive words share no bits
  function automatic logic [31:0] csn_lfsr(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    for (int i = 0; i < 32; i++) begin
      v = v[0] ? ((v >> 1) ^ `CSN_POLY) : (v >> 1);
    end
    return v;
  endfunction

  // box-muller product f*g, std 1/8 in 1.17
  function automatic csn_smp_type csn_gauss(input logic [15:0] f, input logic [5:0] k);
    logic [3:0]        j;
    logic signed [16:0] g;
    j = k[4] ? ~k[3:0] : k[3:0];
    g = signed'({1'b0, CSN_G_TAB[j]});
    if (k[5] ^ k[4]) begin
      g = -g;
    end
    return csn_smp_type'(csn_mul(signed'({1'b0, f}), g, 13));
  endfunction

  // amplitude 2^-x, x in log2 units with 8 fraction bits
  function automatic logic [17:0] csn_amp(input logic signed [17:0] x8);
    logic signed [9:0] xi;
    logic [17:0]       t;
    logic [35:0]       w;
    xi = x8[17:8];
    t  = CSN_P_TAB[x8[7:4]];
    w  = 36'h0;
    if (!xi[9]) begin
      return (xi > 10'sh011) ? 18'h0 : (t >> xi);
    end
    if (-xi > 10'sh011) return `CSN_AMP_MAX;
    w = {18'h0, t} << (-xi);
    return (|w[35:18]) ? `CSN_AMP_MAX : w[17:0];
  endfunction
endpackage

//--- core/csn_buf.sv
// Purpose: two-entry buffer between the stage and the receiver
// Assumes: single clock, valid/ready on both sides
// Notes:   all outputs are flip-flops
module csn_buf #(
  parameter int W = 36
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] spare;
  logic         push;
  assign push = in_valid_i && in_ready_o;

  // head register plus one spare; ready falls only when the spare is held
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      spare       <= '0;
      in_ready_o  <= 1'b1;
    end else if (!out_valid_o || out_ready_i) begin
      out_data_o  <= in_ready_o ? in_data_i : spare;
      out_valid_o <= !in_ready_o || push;
      in_ready_o  <= 1'b1;
    end else if (push) begin
      spare      <= in_data_i;
      in_ready_o <= 1'b0;
    end
  end
endmodule

//--- core/csn_stage.sv
// Purpose: shadowing, noise and power meters of the channel emulator
// Assumes: samples 1.17 signed, one word per decimated sample instant
// Notes:   period of shadow draws is a power of two of samples
`include "csn_regs.svh"
module csn_stage (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire csn_pkg::csn_smp_type in_i_i,
  input  wire csn_pkg::csn_smp_type in_q_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  output csn_pkg::csn_smp_type      out_i_o,
  output csn_pkg::csn_smp_type      out_q_o,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  input  wire logic [7:0]           shadow_sigma_i,
  input  wire logic [4:0]           shadow_period_log2_i,
  input  wire logic [15:0]          noise_scale_coeff_i,
  input  wire logic [26:0]          in_rate_i,
  input  wire logic [7:0]           decim_i,
  input  wire logic                 ovf_clr_i,
  output logic [15:0]               sig_power_o,
  output logic [15:0]               noise_power_o,
  output logic [31:0]               sn0_o,
  output logic                      ovf_o
);
  import csn_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // leading zeros of bits 14:0 of a uniform word, capped at 15
  function automatic logic [3:0] lz16(input logic [15:0] u);
    logic [3:0] n;
    n = 4'hf;
    for (int i = 0; i < 15; i++) begin
      if (u[i]) n = 4'(14 - i);
    end
    return n;
  endfunction

  // ==========================================
  // handshake and uniform sources
  logic        push;
  logic [31:0] lfsr_a;
  logic [31:0] lfsr_b;
  assign push = in_valid_i && in_ready_o;

  // both uniforms advance once per accepted sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_a <= `CSN_SEED_A;
      lfsr_b <= `CSN_SEED_B;
    end else if (push) begin
      lfsr_a <= csn_lfsr(lfsr_a);
      lfsr_b <= csn_lfsr(lfsr_b);
    end
  end

  AST_LFSR_STEP: assert property (push |=> lfsr_a != $past(lfsr_a))
    else $error("uniform source did not advance on an accepted sample");
  AST_LFSR_HOLD: assert property (!push |=> $stable(lfsr_a) && $stable(lfsr_b))
    else $error("uniform source moved without a sample");

  // ==========================================
  // gaussian samples
  csn_smp_type nz [2];
  csn_smp_type shd_n;
  assign nz[0] = csn_gauss(CSN_F_TAB[lz16(lfsr_a[31:16])], lfsr_b[5:0]);
  assign nz[1] = csn_gauss(CSN_F_TAB[lz16(lfsr_a[31:16])], lfsr_b[5:0] - 6'h10);
  assign shd_n = csn_gauss(CSN_F_TAB[lz16(lfsr_b[31:16])], lfsr_a[5:0]);

  // ==========================================
  // shadowing draw and ramp
  logic signed [47:0] l_db;
  logic signed [47:0] x_log2;
  logic [17:0]        new_amp;
  logic [17:0]        tgt;
  logic [47:0]        acc;
  logic signed [63:0] step;
  logic signed [63:0] next_step;
  logic [30:0]        tick;
  logic [30:0]        next_tick;
  logic [17:0]        amp;
  logic               shd_off;

  assign shd_off   = shadow_sigma_i == 8'h0;
  assign l_db      = csn_mul(shd_n, signed'({1'b0, shadow_sigma_i}), 0);
  assign x_log2    = csn_mul(l_db[31:0], `CSN_DB2LOG2, 26);
  assign new_amp   = csn_amp(x_log2[17:0]);
  assign next_step = ((64'(signed'({1'b0, new_amp})) - 64'(signed'({1'b0, tgt})))
                      <<< `CSN_ACC_FRAC) >>> shadow_period_log2_i;
  assign next_tick = (tick == ((31'h1 << shadow_period_log2_i) - 31'h1)) ? 31'h0
                                                                          : tick + 31'h1;
  assign amp       = shd_off ? `CSN_UNITY : acc[47:30];

  // draw on the first sample of each period, ramp on the others
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc  <= {`CSN_UNITY, 30'h0};
      tgt  <= `CSN_UNITY;
      step <= 64'sh0;
      tick <= 31'h0;
    end else if (shd_off) begin
      acc  <= {`CSN_UNITY, 30'h0};
      tgt  <= `CSN_UNITY;
      step <= 64'sh0;
      tick <= 31'h0;
    end else if (push) begin
      if (tick == 31'h0) begin
        acc  <= {tgt, 30'h0};
        tgt  <= new_amp;
        step <= next_step;
      end else begin
        acc <= acc + step[47:0];
      end
      tick <= next_tick;
    end
  end

  AST_BYPASS: assert property (shd_off |=> amp == `CSN_UNITY)
    else $error("shadowing active with zero deviation");
  AST_DRAW: assert property (push && !shd_off && tick == 31'h0 && !$fell(rst_n_i) ##1 !shd_off
                             |-> tgt == $past(new_amp) && acc[47:30] == $past(tgt))
    else $error("draw did not load the new target");
  AST_RAMP: assert property (push && !shd_off && tick != 31'h0 ##1 !shd_off
                             |-> acc == $past(acc) + $past(step[47:0]))
    else $error("attenuation did not ramp by one step");

  // ==========================================
  // per channel: shadow, scale noise, sum
  csn_smp_type x [2];
  csn_smp_type sh [2];
  csn_smp_type ns [2];
  csn_smp_type y [2];
  logic [1:0]  ovf_ch;
  logic [15:0] sq_sig [2];
  logic [15:0] sq_nz [2];
  assign x[0] = in_i_i;
  assign x[1] = in_q_i;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [47:0] sh_w;
    logic signed [47:0] ns_w;
    logic signed [47:0] y_w;
    logic signed [47:0] sqs;
    logic signed [47:0] sqn;
    assign sh_w      = csn_mul(x[c], signed'({1'b0, amp}), 16);
    assign sh[c]     = csn_sat(sh_w);
    assign ns_w      = csn_mul(nz[c], signed'({1'b0, noise_scale_coeff_i}), 15);
    assign ns[c]     = csn_sat(ns_w);
    assign y_w       = 48'(sh[c]) + 48'(ns[c]);
    assign y[c]      = csn_sat(y_w);
    assign ovf_ch[c] = csn_ovf(sh_w) || csn_ovf(ns_w) || csn_ovf(y_w);
    assign sqs       = csn_mul(x[c], x[c], 0);
    assign sqn       = csn_mul(ns[c], ns[c], 0);
    assign sq_sig[c] = sqs[34:19];
    assign sq_nz[c]  = sqn[34:19];

    AST_SIGN: assert property (push && amp != 18'h0 && x[c] != 18'sh0
                               |-> sh[c] == 18'sh0 || sh[c][17] == x[c][17])
      else $error("shadowed sample changed sign");
  end

  // ==========================================
  // output buffer and sticky overflow
  csn_buf #(
    .W (36)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (in_valid_i),
    .in_data_i   ({y[0], y[1]}),
    .in_ready_o  (in_ready_o),
    .out_valid_o (out_valid_o),
    .out_data_o  ({out_i_o, out_q_o}),
    .out_ready_i (out_ready_i)
  );

  // a new overflow wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_o <= 1'b0;
    end else if (push && |ovf_ch) begin
      ovf_o <= 1'b1;
    end else if (ovf_clr_i) begin
      ovf_o <= 1'b0;
    end
  end

  AST_OVF_SET: assert property (push && |ovf_ch |=> ovf_o)
    else $error("saturation did not raise the overflow flag");
  AST_OVF_KEEP: assert property (ovf_o && !ovf_clr_i |=> ovf_o)
    else $error("overflow flag dropped without a clear");

  // ==========================================
  // running power meters
  logic [15:0] sig_hist [`CSN_AVG_LEN];
  logic [15:0] nz_hist [`CSN_AVG_LEN];
  logic [16:0] sig_new;
  logic [16:0] nz_new;
  logic [26:0] sig_sum;
  logic [26:0] nz_sum;
  logic [9:0]  wp;
  logic        full;
  assign sig_new = 17'(sq_sig[0]) + 17'(sq_sig[1]);
  assign nz_new  = 17'(sq_nz[0]) + 17'(sq_nz[1]);

  // window memory, one word per channel sum
  always_ff @(posedge clk_i) begin
    if (push) begin
      sig_hist[wp] <= sig_new[16:1];
      nz_hist[wp]  <= nz_new[16:1];
    end
  end

  // sum over the last 1024 samples, oldest word leaves as a new one enters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sig_sum       <= 27'h0;
      nz_sum        <= 27'h0;
      wp            <= 10'h0;
      full          <= 1'b0;
      sig_power_o   <= 16'h0;
      noise_power_o <= 16'h0;
    end else begin
      if (push) begin
        sig_sum <= sig_sum + 27'(sig_new[16:1]) - (full ? 27'(sig_hist[wp]) : 27'h0);
        nz_sum  <= nz_sum + 27'(nz_new[16:1]) - (full ? 27'(nz_hist[wp]) : 27'h0);
        wp      <= wp + 10'h1;
        full    <= full || (wp == 10'h3ff);
      end
      sig_power_o   <= sig_sum[`CSN_AVG_LOG2 +: 16];
      noise_power_o <= nz_sum[`CSN_AVG_LOG2 +: 16];
    end
  end

  AST_SUM_RANGE: assert property (sig_sum <= 27'(`CSN_AVG_LEN) * 27'hffff)
    else $error("signal power sum left its window range");

  // ==========================================
  // S/N0 divider: (S * rate) / (N * R)
  csn_div_state_type  dv_state;
  logic [42:0]        dv_q;
  logic [23:0]        dv_den;
  logic [24:0]        dv_rem;
  logic [24:0]        next_rem;
  logic [5:0]         dv_cnt;
  assign next_rem = {dv_rem[23:0], dv_q[42]};

  // restoring division, one quotient bit a cycle, result published when idle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dv_state <= CSN_DIV_IDLE;
      dv_q     <= 43'h0;
      dv_den   <= 24'h0;
      dv_rem   <= 25'h0;
      dv_cnt   <= 6'h0;
      sn0_o    <= 32'h0;
    end else begin
      case (dv_state)
        CSN_DIV_IDLE: begin
          sn0_o    <= (dv_den == 24'h0 || |dv_q[42:32]) ? 32'hffffffff : dv_q[31:0];
          dv_q     <= 43'(sig_power_o * in_rate_i);
          dv_den   <= 24'(noise_power_o * decim_i);
          dv_rem   <= 25'h0;
          dv_cnt   <= `CSN_DIV_STEPS;
          dv_state <= CSN_DIV_RUN;
        end
        CSN_DIV_RUN: begin
          if (next_rem >= {1'b0, dv_den}) begin
            dv_rem <= next_rem - {1'b0, dv_den};
            dv_q   <= {dv_q[41:0], 1'b1};
          end else begin
            dv_rem <= next_rem;
            dv_q   <= {dv_q[41:0], 1'b0};
          end
          dv_cnt <= dv_cnt - 6'h1;
          if (dv_cnt == 6'h1) dv_state <= CSN_DIV_IDLE;
        end
        default: dv_state <= CSN_DIV_IDLE;
      endcase
    end
  end

  AST_DIV_LEN: assert property ($rose(dv_state == CSN_DIV_RUN)
                                |-> ##43 dv_state == CSN_DIV_IDLE)
    else $error("division did not take 43 steps");
endmodule

//--- test/csn_partner.sv
// Purpose: upstream sample source and downstream receiver of the stage
// Assumes: all signals change 1 ns after the rising edge
// Notes:   idle data lines show the inverse of the last word offered
module csn_partner (
  input  wire logic            clk_i,
  input  wire logic            in_ready_i,
  output csn_pkg::csn_smp_type smp_i_o,
  output csn_pkg::csn_smp_type smp_q_o,
  output logic                 valid_o,
  output logic                 sink_ready_o,
  input  wire logic [7:0]      stall_pct_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import csn_pkg::*;
  int seed = 32'h056e6d44;

  initial begin
    smp_i_o      = '0;
    smp_q_o      = '0;
    valid_o      = 1'b0;
    sink_ready_o = 1'b0;
  end

  // ==========================================
  // source: holds the word until the edge that takes it
  task automatic send(input csn_smp_type i, input csn_smp_type q);
    smp_i_o = i;
    smp_q_o = q;
    valid_o = 1'b1;
    while (!in_ready_i) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
  endtask

  // release the lines, data shows the inverse of the last word
  task automatic idle();
    valid_o = 1'b0;
    smp_i_o = ~smp_i_o;
    smp_q_o = ~smp_q_o;
  endtask

  // ==========================================
  // receiver: stalls at random with the given percentage
  always @(posedge clk_i) begin
    #1;
    sink_ready_o = ($unsigned($random(seed)) % 100) >= stall_pct_i;
  end
endmodule

//--- test/tb_channel_shadowing_noise_stage.sv
// Purpose: self-checking bench of the shadowing and noise stage
// Assumes: stage output equals input when sigma and noise scale are zero
// Notes:   noisy and shadowed runs are judged by bounds and statistics
module tb_channel_shadowing_noise_stage;
  timeunit 1ns;
  timeprecision 100ps;
  import csn_pkg::*;

  // ==========================================
  // signals
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  csn_smp_type in_i, in_q, out_i, out_q;
  logic        in_valid, in_ready, out_valid, out_ready;
  logic [7:0]  sigma = 8'h00;
  logic [4:0]  per = 5'h03;
  logic [15:0] coeff = 16'h0000;
  logic        ovf_clr = 1'b0;
  logic [15:0] sig_pw, noise_pw;
  logic [31:0] sn0;
  logic        ovf;
  logic [7:0]  stall = 8'h00;
  logic [26:0] rate = 27'd1000000;
  logic [7:0]  decim = 8'h04;
  longint      q = 0;
  logic [35:0] mdl_q[$];
  logic [35:0] exp_w;
  int          obs_i[$], obs_q[$];
  int          mismatches = 0, samples_checked = 0, n_in = 0, n_out = 0, p1 = 0;
  int          seed = 32'h056e6d44;
  bit          exact = 1'b1;

  always #2 clk_i = ~clk_i;

  csn_stage uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_i_i(in_i), .in_q_i(in_q),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .out_i_o(out_i), .out_q_o(out_q),
    .out_valid_o(out_valid), .out_ready_i(out_ready), .shadow_sigma_i(sigma),
    .shadow_period_log2_i(per), .noise_scale_coeff_i(coeff), .in_rate_i(rate),
    .decim_i(decim), .ovf_clr_i(ovf_clr), .sig_power_o(sig_pw), .noise_power_o(noise_pw),
    .sn0_o(sn0), .ovf_o(ovf));

  csn_partner part (.clk_i(clk_i), .in_ready_i(in_ready), .smp_i_o(in_i), .smp_q_o(in_q),
    .valid_o(in_valid), .sink_ready_o(out_ready), .stall_pct_i(stall));

  // ==========================================
  // comparison and verdict
  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // monitor: transfers are settled at the falling edge before the taking edge
  always @(negedge clk_i) begin
    if (rst_n_i && in_valid && in_ready) n_in++;
    if (rst_n_i && out_valid && out_ready) begin
      n_out++;
      obs_i.push_back(int'(out_i));
      obs_q.push_back(int'(out_q));
      if (mdl_q.size() > 0) exp_w = mdl_q.pop_front();
      if (exact) check({28'h0, out_i, out_q}, {28'h0, exp_w});
    end
  end

  // ==========================================
  // stimulus helpers
  task automatic push(input csn_smp_type i, input csn_smp_type q);
    mdl_q.push_back({i, q});
    part.send(i, q);
  endtask

  task automatic burst(input int n, input bit rnd, input csn_smp_type v);
    obs_i.delete();
    obs_q.delete();
    for (int k = 0; k < n; k++) begin
      if (rnd) push(csn_smp_type'($random(seed)), csn_smp_type'($random(seed)));
      else push(v, v);
    end
    part.idle();
    for (int k = 0; k < 5000 && mdl_q.size() > 0; k++) @(posedge clk_i);
    check(mdl_q.size() == 0, 1'b1);
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // statistics of the collected I outputs, one of them comparing I against Q
  function automatic int stat(input int what);
    int r = 0;
    for (int k = 0; k < obs_i.size(); k++) begin
      int d;
      d = (k == 0) ? 0 : obs_i[k] - obs_i[k-1];
      d = (d < 0) ? -d : d;
      case (what)
        0: r = (d > r) ? d : r;
        1: r += (k > 0 && d == 0);
        2: r += obs_i[k];
        3: r += (obs_i[k] != obs_q[k]);
        4: r += (obs_i[k] < 0);
        5: r += (obs_i[k] == 131071);
        default: r += (obs_i[k] != 65536);
      endcase
    end
    return r;
  endfunction

  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    check({in_ready, out_valid, ovf}, 3'b100);
    check({sig_pw, noise_pw, sn0}, 64'h0);
    rst_n_i = 1'b1;
    // pass-through with random words and random receiver stalls
    stall = 8'd30;
    burst(200, 1'b1, '0);
    repeat (50) @(posedge clk_i);
    #1;
    check(noise_pw, 16'h0000);
    check(sn0, 32'hffffffff);
    // signal power of a constant half-scale tone
    stall = 8'd0;
    burst(1100, 1'b0, 18'h10000);
    // each channel 0.5 squared lands as 0x2000 in the mean of (i^2+q^2)/2
    check(sig_pw, 16'h2000);
    check(sig_pw, 16'h2000);
    // buffer fills with the receiver stalled, then drains in order
    stall = 8'd100;
    p1 = n_in;
    fork
      burst(3, 1'b1, '0);
    join_none
    repeat (8) @(posedge clk_i);
    #1;
    check(n_in - p1, 2);
    check(in_ready, 1'b0);
    #1 stall = 8'd0;
    wait fork;
    // noise only: statistics and power against the scale coefficient
    exact = 1'b0;
    coeff = 16'h8000;
    burst(1100, 1'b0, '0);
    p1 = noise_pw;
    check(p1 >= 'h100 && p1 <= 'h400, 1'b1);
    check(stat(1) < 55, 1'b1);
    check(stat(2) < 1100 * 2048 && stat(2) > -1100 * 2048, 1'b1);
    repeat (100) @(posedge clk_i);
    #1;
    check(sn0, 32'h0);
    coeff = 16'h4000;
    burst(1100, 1'b0, '0);
    check(noise_pw * 8 >= p1 && noise_pw * 2 <= p1, 1'b1);
    // full-scale input with strong noise saturates without sign flip
    coeff = 16'hffff;
    decim = 8'h03;
    burst(200, 1'b0, 18'h1ffff);
    check(stat(4), 0);
    check(stat(5) > 0, 1'b1);
    check(ovf, 1'b1);
    ovf_clr = 1'b1;
    @(posedge clk_i);
    #1;
    check(ovf, 1'b0);
    ovf_clr = 1'b0;
    // window holds 200 full-scale words and 824 zero words: 200*0x7fff/1024
    repeat (100) @(posedge clk_i);
    #1;
    check(sig_pw, 16'h18ff);
    q = longint'(16'h18ff) * rate / (longint'(noise_pw) * decim);
    check(sn0, (noise_pw == 16'h0 || q > 64'hffffffff) ? 64'hffffffff : 64'(q));
    // shadowing only: ramps between draws, same gain on I and Q
    coeff = 16'h0000;
    // a period of 16 keeps every ramp step under a quarter of full scale
    per = 5'h04;
    sigma = 8'h60;
    stall = 8'd20;
    burst(300, 1'b0, 18'h10000);
    check(stat(0) <= 'h4400, 1'b1);
    check(stat(3), 0);
    check(stat(6) > 0, 1'b1);
    check(stat(1) < 150, 1'b1);
    check(stat(4), 0);
    // sigma back to zero gives plain pass-through again
    sigma = 8'h00;
    exact = 1'b1;
    burst(20, 1'b1, '0);
    stop_test();
  end

  // watchdog against a hung handshake
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
